//--- sarseq_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
`ifndef SARSEQ_DEFS_SVH
`define SARSEQ_DEFS_SVH
`define SARSEQ_RESULT_IDX 8'h70
`define SARSEQ_CSR_IDX 8'h71
`define SARSEQ_RESULT_ADDR 12'h1c0
`define SARSEQ_CSR_ADDR 12'h1c4
`define SARSEQ_INT_STATUS_ADDR 12'h1c8
`define SARSEQ_INT_MASK_ADDR 12'h1cc
`define SARSEQ_DONE_BIT 7
`define SARSEQ_ON_BIT 5
`define SARSEQ_SEL_MSB 3
`define SARSEQ_SEL_LSB 0
`define SARSEQ_CSR_WMASK 8'h2f
`define SARSEQ_CSR_RESET 8'h00
`define SARSEQ_RESULT_RESET 8'h00
`define SARSEQ_CONV_CLOCKS 12
`define SARSEQ_APPROX_STEPS 8
`define SARSEQ_SAMPLE_CLOCKS 4
`define SARSEQ_CORE_PER_CONV 2
`endif

//--- sarseq_pkg.sv
// Types shared by the converter sequencer.
package sarseq_pkg;
   typedef enum logic [1:0] {
      SARSEQ_OFF,
      SARSEQ_SAMPLE,
      SARSEQ_APPROX
   } sarseq_phase_t;
   typedef logic [1:0] sarseq_resp_t;
endpackage : sarseq_pkg

//--- sarseq_top.sv
// Sequencer for an 8-bit successive-approximation converter with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "sarseq_defs.svh"
module sarseq_top #(
   parameter int STEPS = `SARSEQ_APPROX_STEPS,
   parameter int SAMPLE_CLOCKS = `SARSEQ_SAMPLE_CLOCKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output sarseq_pkg::sarseq_resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output sarseq_pkg::sarseq_resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic halt_mode,
   input wire logic comparator_high,
   output logic converter_power,
   output logic sample_switch,
   output logic [3:0] input_select,
   output logic [STEPS-1:0] trial_code,
   output logic irq
);
   import sarseq_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [11:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      sarseq_resp_t bresp;
      logic rvalid;
      sarseq_resp_t rresp;
      logic [31:0] rdata;
      logic converter_on;
      logic [3:0] sel;
      logic done_flag;
      logic [7:0] result;
      sarseq_phase_t phase;
      logic half;
      logic [3:0] clk_count;
      logic [4:0] conv_age;
      logic [STEPS-1:0] trial;
      logic [STEPS-1:0] bit_ptr;
      logic int_status;
      logic int_mask;
   } sarseq_state_t;

   sarseq_state_t s_reg;
   sarseq_state_t s_next;

   logic do_write;
   logic do_read;
   logic csr_write;
   logic result_read;
   logic conv_tick;
   logic conv_finish;
   logic [STEPS-1:0] decided;

   assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
   assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
   assign s_axi_arready = !s_reg.rvalid;
   assign do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign csr_write = do_write && s_reg.aw_addr == `SARSEQ_CSR_ADDR && s_reg.w_strb[0];
   assign result_read = do_read && s_axi_araddr == `SARSEQ_RESULT_ADDR;
   assign conv_tick = s_reg.half;
   // The last approximation step ends on the closing converter clock of the conversion.
   assign conv_finish = conv_tick && s_reg.phase == SARSEQ_APPROX && s_reg.bit_ptr[0];

   // Trial value of the current step keeps the bit under test only if the comparator says the input is higher.
   for (genvar i = 0; i < STEPS; i++) begin : g_bits
      assign decided[i] = s_reg.bit_ptr[i] ? comparator_high : s_reg.trial[i];
   end

   always_comb begin
      s_next = s_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.aw_held = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.w_held = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end

      // Converter sequencing runs on every other core clock.
      s_next.half = !s_reg.half;
      case (s_reg.phase)
         SARSEQ_OFF: begin
            s_next.half = 1'b0;
            s_next.clk_count = 4'h0;
            // A converter left on through halt resumes by itself once halt is released.
            if (s_reg.converter_on && !halt_mode) begin
               s_next.phase = SARSEQ_SAMPLE;
            end
         end
         SARSEQ_SAMPLE: begin
            if (conv_tick) begin
               s_next.clk_count = s_reg.clk_count + 4'h1;
               if (s_reg.clk_count == 4'(SAMPLE_CLOCKS - 1)) begin
                  s_next.phase = SARSEQ_APPROX;
                  s_next.bit_ptr = {1'b1, {(STEPS-1){1'b0}}};
                  s_next.trial = {1'b1, {(STEPS-1){1'b0}}};
               end
            end
         end
         SARSEQ_APPROX: begin
            if (conv_tick) begin
               s_next.clk_count = s_reg.clk_count + 4'h1;
               s_next.trial = decided | (s_reg.bit_ptr >> 1);
               s_next.bit_ptr = s_reg.bit_ptr >> 1;
               if (s_reg.bit_ptr[0]) begin
                  // Saturation follows from the comparator: all ones above the top, zero below the bottom.
                  s_next.result = 8'(decided);
                  s_next.done_flag = 1'b1;
                  s_next.int_status = 1'b1;
                  s_next.phase = SARSEQ_SAMPLE;
                  s_next.clk_count = 4'h0;
               end
            end
         end
         default: begin
            s_next.phase = SARSEQ_OFF;
         end
      endcase

      if (result_read) begin
         s_next.done_flag = 1'b0;
      end

      if (do_write) begin
         s_next.aw_held = 1'b0;
         s_next.w_held = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = 2'b00;
         case (s_reg.aw_addr)
            `SARSEQ_CSR_ADDR: begin
               if (s_reg.w_strb[0]) begin
                  // Reserved bits are dropped, so they always read as zero.
                  s_next.converter_on = s_reg.w_data[`SARSEQ_ON_BIT];
                  s_next.sel = s_reg.w_data[`SARSEQ_SEL_MSB:`SARSEQ_SEL_LSB];
                  s_next.done_flag = 1'b0;
                  if (s_reg.w_data[`SARSEQ_ON_BIT]) begin
                     s_next.phase = SARSEQ_SAMPLE;
                     s_next.half = 1'b0;
                     s_next.clk_count = 4'h0;
                  end
               end
            end
            `SARSEQ_INT_STATUS_ADDR: begin
               if (s_reg.w_strb[0] && s_reg.w_data[0] && !conv_finish) begin
                  s_next.int_status = 1'b0;
               end
            end
            `SARSEQ_INT_MASK_ADDR: begin
               if (s_reg.w_strb[0]) begin
                  s_next.int_mask = s_reg.w_data[0];
               end
            end
            `SARSEQ_RESULT_ADDR: begin
            end
            default: begin
               s_next.bresp = 2'b10;
            end
         endcase
      end

      // Switching off or halting abandons the conversion without touching result; a CSR write that switches off also clears the flag.
      if (!s_next.converter_on || halt_mode) begin
         s_next.phase = SARSEQ_OFF;
      end
      if (halt_mode && !s_reg.converter_on) begin
         s_next.phase = SARSEQ_OFF;
      end

      // Core cycles since the current conversion opened.
      // It is kept apart from the phase counters so that the length check does not lean on them.
      if (s_next.phase == SARSEQ_SAMPLE && (s_reg.phase != SARSEQ_SAMPLE || conv_finish || csr_write)) begin
         s_next.conv_age = 5'h00;
      end else if (s_reg.conv_age != 5'h1f) begin
         s_next.conv_age = s_reg.conv_age + 5'h01;
      end

      if (do_read) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = 2'b00;
         case (s_axi_araddr)
            `SARSEQ_RESULT_ADDR: s_next.rdata = {24'h000000, s_reg.result};
            `SARSEQ_CSR_ADDR: s_next.rdata = {24'h000000, s_reg.done_flag, 1'b0, s_reg.converter_on, 1'b0, s_reg.sel};
            `SARSEQ_INT_STATUS_ADDR: s_next.rdata = {31'h00000000, s_reg.int_status};
            `SARSEQ_INT_MASK_ADDR: s_next.rdata = {31'h00000000, s_reg.int_mask};
            default: begin
               s_next.rdata = 32'h00000000;
               s_next.rresp = 2'b10;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
         s_reg.phase <= SARSEQ_OFF;
         s_reg.result <= `SARSEQ_RESULT_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rresp = s_reg.rresp;
   assign s_axi_rdata = s_reg.rdata;
   assign converter_power = s_reg.converter_on && !halt_mode;
   assign sample_switch = s_reg.phase == SARSEQ_SAMPLE;
   assign input_select = s_reg.sel;
   assign trial_code = s_reg.trial;
   // This line is the wrapper's own event output; the converter itself raises no request.
   assign irq = s_reg.int_status && s_reg.int_mask;

   // A conversion that is neither aborted nor halted finishes on its 24th core cycle.
   conv_total_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_finish |-> s_reg.conv_age == 5'(`SARSEQ_CONV_CLOCKS * `SARSEQ_CORE_PER_CONV - 1))
      else $error("Conversion did not last 12 converter clocks.");

   step_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_finish |-> s_reg.clk_count == 4'(`SARSEQ_CONV_CLOCKS - 1))
      else $error("Conversion step count wrong at finish.");

   // The sticky status bit wins over a clear that falls in the same cycle.
   status_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_finish |=> s_reg.int_status) else $error("Status bit not set at finish.");

   reset_load_a: assert property (@(posedge aclk)
      !aresetn |=> s_reg.result == `SARSEQ_RESULT_RESET && !s_reg.converter_on && !s_reg.done_flag)
      else $error("Reset did not clear the converter state.");

   bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before it was taken.");

   rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped before it was taken.");

   sequence halt_end_s;
      halt_mode ##1 !halt_mode;
   endsequence
   halt_resume_a: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_end_s ##0 (s_reg.converter_on && !do_write) |=> s_reg.phase == SARSEQ_SAMPLE)
      else $error("Converter did not resume after halt.");

   ro_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && s_reg.aw_addr == `SARSEQ_RESULT_ADDR && !conv_finish |=> $stable(s_reg.result))
      else $error("Result register took a write.");

   sel_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !csr_write |=> $stable(input_select) && $stable(s_reg.converter_on))
      else $error("Control bits changed without a write.");

   done_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !conv_finish && !result_read && !csr_write |=> $stable(s_reg.done_flag))
      else $error("Done flag changed without cause.");

   sequence approx_start_s;
      s_reg.phase == SARSEQ_SAMPLE ##1 s_reg.phase == SARSEQ_APPROX;
   endsequence
   approx_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
      approx_start_s |-> !sample_switch && s_reg.bit_ptr[STEPS-1]) else $error("Approximation began wrongly.");

   loop_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_finish && s_reg.converter_on && !do_write && !halt_mode |=> s_reg.phase == SARSEQ_SAMPLE)
      else $error("Converter did not restart sampling.");

   start_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
      csr_write && s_reg.w_data[`SARSEQ_ON_BIT] && !halt_mode |=> s_reg.phase == SARSEQ_SAMPLE && s_reg.clk_count == 4'h0)
      else $error("Conversion did not start on enable.");

   done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_finish && !result_read && !csr_write |=> s_reg.done_flag) else $error("Done flag not set.");

   result_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(conv_finish) |-> $stable(s_reg.result)) else $error("Result changed between conversions.");

   flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (result_read || csr_write) |=> !s_reg.done_flag) else $error("Done flag not cleared.");

   off_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      csr_write && !s_reg.w_data[`SARSEQ_ON_BIT] |=> s_reg.phase == SARSEQ_OFF && $stable(s_reg.result))
      else $error("Switch-off did not abandon conversion.");

   halt_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_mode |-> !converter_power ##1 s_reg.phase == SARSEQ_OFF) else $error("Halt left converter on.");

   sel_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      csr_write |=> input_select == $past(s_reg.w_data[3:0])) else $error("Input select mismatch.");
endmodule : sarseq_top

//--- sarseq_front_model.sv
// Behavioural analog multiplexer and comparator that face the converter sequencer.
`timescale 1ns/1ns
module sarseq_front_model (
   input wire logic aclk,
   input wire logic converter_power,
   input wire logic sample_switch,
   input wire logic [3:0] input_select,
   input wire logic [7:0] trial_code,
   input wire logic [7:0] levels [16],
   output logic comparator_high
);
   logic [7:0] held;
   logic flip = 1'b0;
   // The capacitor keeps its charge once the switch opens, so a later channel change cannot leak in.
   always @(posedge aclk) begin
      flip <= !flip;
      if (sample_switch) begin
         held <= levels[input_select];
      end
   end
   // A level sits half a step above its code, so a full-scale input keeps every trial bit.
   // An unpowered comparator gives a toggling answer rather than a stable guess.
   assign comparator_high = converter_power ? (held >= trial_code) : flip;
endmodule : sarseq_front_model

//--- tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ns
`include "sarseq_defs.svh"
module tb;
   import sarseq_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m; sarseq_resp_t r;} sarseq_note_t;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halt_mode;
   logic awready, wready, bvalid, arready, rvalid, cmp_hi, pwr, smp, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, sel;
   logic [7:0] trial;
   logic [7:0] lvl [16];
   sarseq_resp_t bresp, rresp, br;
   sarseq_note_t q [$];
   sarseq_note_t e;
   int failures = 0;
   int samples_checked = 0;
   int n;
   sarseq_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .halt_mode(halt_mode),
      .comparator_high(cmp_hi), .converter_power(pwr), .sample_switch(smp), .input_select(sel),
      .trial_code(trial), .irq(irq));
   sarseq_front_model fe_u (.aclk(aclk), .converter_power(pwr), .sample_switch(smp), .input_select(sel),
      .trial_code(trial), .levels(lvl), .comparator_high(cmp_hi));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   // Ready is looked at half a cycle early; it cannot move before the next rising edge.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tb_;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tb_ = bvalid;
         br = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb_);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input sarseq_resp_t r);
      logic ta, tr;
      q.push_back('{v, m, r});
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arready;
         tr = rvalid;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
   endtask : rd
   task automatic span(input logic lv);
      // The falling edge that ended the previous span already showed this level.
      n = 1;
      @(negedge aclk);
      while (smp === lv && n < 100) begin
         n++;
         @(negedge aclk);
      end
      @(posedge aclk);
   endtask : span
   always @(posedge aclk) begin
      if (rvalid && rready && q.size() > 0) begin
         e = q.pop_front();
         chk("rdata", rdata & e.m, e.v);
         chk("rresp", {30'h0, rresp}, {30'h0, e.r});
      end
   end
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      complete_run();
   end
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      halt_mode = 1'b0;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'h1;
      void'($urandom(25));
      foreach (lvl[i]) lvl[i] = 8'($urandom());
      lvl[0] = 8'h00;
      lvl[15] = 8'hff;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`SARSEQ_RESULT_ADDR, 32'h0, 32'hffffffff, 2'b00);
      rd(`SARSEQ_CSR_ADDR, 32'h0, 32'hffffffff, 2'b00);
      rd(12'h1d0, 32'h0, 32'hffffffff, 2'b10);
      wr(`SARSEQ_RESULT_ADDR, 32'h5a);
      rd(`SARSEQ_RESULT_ADDR, 32'h0, 32'hffffffff, 2'b00);
      wr(12'h1d0, 32'h1);
      chk("bresp", {30'h0, br}, 32'h2);
      for (int c = 0; c < 16; c++) begin
         wr(`SARSEQ_CSR_ADDR, 32'h20 | c);
         span(1'b0);
         span(1'b1);
         span(1'b0);
         chk("approx_span", n, 32'd16);
         span(1'b1);
         chk("sample_span", n, 32'd8);
         chk("input_select", {28'h0, sel}, c);
         chk("irq_masked", {31'h0, irq}, 32'h0);
         rd(`SARSEQ_CSR_ADDR, 32'ha0 | c, 32'hbf, 2'b00);
         rd(`SARSEQ_RESULT_ADDR, {24'h0, lvl[c]}, 32'hffffffff, 2'b00);
         rd(`SARSEQ_CSR_ADDR, 32'h0, 32'h80, 2'b00);
      end
      rd(`SARSEQ_INT_STATUS_ADDR, 32'h1, 32'h1, 2'b00);
      wr(`SARSEQ_INT_MASK_ADDR, 32'h1);
      chk("irq_on", {31'h0, irq}, 32'h1);
      span(1'b0);
      span(1'b1);
      repeat (4) @(posedge aclk);
      wr(`SARSEQ_CSR_ADDR, 32'h2f);
      @(negedge aclk);
      chk("restart", {31'h0, smp}, 32'h1);
      @(posedge aclk);
      rd(`SARSEQ_CSR_ADDR, 32'h2f, 32'hff, 2'b00);
      halt_mode <= 1'b1;
      @(negedge aclk);
      chk("halt_power", {31'h0, pwr}, 32'h0);
      @(posedge aclk);
      halt_mode <= 1'b0;
      @(negedge aclk);
      chk("power", {31'h0, pwr}, 32'h1);
      span(1'b0);
      span(1'b1);
      repeat (3) @(posedge aclk);
      wr(`SARSEQ_CSR_ADDR, 32'h0f);
      repeat (40) @(posedge aclk);
      chk("off_sample", {31'h0, smp}, 32'h0);
      rd(`SARSEQ_RESULT_ADDR, {24'h0, lvl[15]}, 32'hffffffff, 2'b00);
      rd(`SARSEQ_CSR_ADDR, 32'h0f, 32'hff, 2'b00);
      wr(`SARSEQ_INT_STATUS_ADDR, 32'h1);
      chk("irq_clear", {31'h0, irq}, 32'h0);
      rd(`SARSEQ_INT_STATUS_ADDR, 32'h0, 32'h1, 2'b00);
      complete_run();
   end
endmodule : tb
